// >>> core/mcs_pkg.sv
/*
  Constants, types and register map of the multichannel channel-select
  block of a buffered serial port.
  Assumes a single 25 MHz clock domain; frame and word strobes come from
  the serial shifters on the same clock.
*/
package mcs_pkg;

  // ----------------------------------------------------------------------
  // Register map (byte addresses of one 32-bit word each; extended banks are addr[7:4] pages of four words)
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_RX_BASIC = 8'h04;
  localparam logic [7:0] OFF_TX_BASIC = 8'h08;
  localparam logic [3:0] OFF_RX_EXT_PAGE = 4'h1;
  localparam logic [3:0] OFF_TX_EXT_PAGE = 4'h2;

  // ----------------------------------------------------------------------
  // Control register field positions
  // ----------------------------------------------------------------------
  localparam int POS_RX_MODE = 0;
  localparam int POS_RESERVED = 1;
  localparam int POS_RX_CUR = 2;
  localparam int POS_RX_EVEN = 5;
  localparam int POS_RX_ODD = 7;
  localparam int POS_RX_WIDE = 9;
  localparam int POS_TX_MODE = 16;
  localparam int POS_TX_CUR = 18;
  localparam int POS_TX_EVEN = 21;
  localparam int POS_TX_ODD = 23;
  localparam int POS_TX_WIDE = 25;

  // ----------------------------------------------------------------------
  // Reset values and limits
  // ----------------------------------------------------------------------
  localparam logic [31:0] RST_ENABLE = 32'h0000_0000;
  localparam logic [6:0] LAST_CHAN = 7'h7F;

  // Transmit multichannel modes.
  typedef enum logic [1:0] {
    MCS_TX_ALL = 2'h0,
    MCS_TX_SELECT = 2'h1,
    MCS_TX_MASKED = 2'h2,
    MCS_TX_SYMMETRIC = 2'h3
  } mcs_tx_mode_t;

  // Writable control fields.
  typedef struct packed {
    logic tx_wide_select_enable;
    logic [1:0] tx_odd_block_select;
    logic [1:0] tx_even_block_select;
    mcs_tx_mode_t tx_select_mode;
    logic rx_wide_select_enable;
    logic [1:0] rx_odd_block_select;
    logic [1:0] rx_even_block_select;
    logic rx_select_mode;
  } mcs_ctrl_t;

  localparam mcs_ctrl_t RST_CTRL = '{
    tx_wide_select_enable: 1'b0,
    tx_odd_block_select: 2'h0,
    tx_even_block_select: 2'h0,
    tx_select_mode: MCS_TX_ALL,
    rx_wide_select_enable: 1'b0,
    rx_odd_block_select: 2'h0,
    rx_even_block_select: 2'h0,
    rx_select_mode: 1'b0
  };

  // Register bus request.
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } mcs_bus_t;

  // Frame timing and transmit data from the shifters.
  typedef struct packed {
    logic rx_frame_start;
    logic rx_word_done;
    logic tx_frame_start;
    logic tx_word_done;
    logic tx_active;
    logic tx_bit;
  } mcs_slot_t;

  // Whole state of the block.
  typedef struct packed {
    mcs_ctrl_t ctrl;
    logic [3:0][31:0] rx_en;
    logic [3:0][31:0] tx_en;
    logic [6:0] rx_chan;
    logic [6:0] tx_chan;
    logic [2:0] rx_cur;
    logic [2:0] tx_cur;
    logic rx_accept;
    logic tx_enable;
    logic tx_unmask;
    logic dx;
    logic dx_oe;
    logic [31:0] rdata;
  } mcs_state_t;

endpackage

// >>> core/mcs_channel_select.sv
/*
  Multichannel channel-select logic: decides per time slot whether the
  receiver accepts the word and whether the transmitter enables, masks
  or drives it, and holds the channel-enable registers.
  Assumes the shifters supply one-cycle frame-start and word-done strobes
  on clk, and that the pad ring resolves the data pin from its enable.
*/
// Added by the designer: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none

module mcs_channel_select
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Register bus
  input wire mcs_pkg::mcs_bus_t bus,
  output logic [31:0] rdata,
  // Slot timing and transmit bit from the shifters
  input wire mcs_pkg::mcs_slot_t slot,
  // Channel decisions
  output logic [2:0] rx_current_block,
  output logic [2:0] tx_current_block,
  output logic rx_accept,
  output logic tx_enable,
  output logic tx_unmask,
  // Serial data pin, released when the enable is low
  output logic serial_data_out_pin,
  output logic serial_data_out_pin_oe
);

  // ----------------------------------------------------------------------
  // Channel lookup
  // ----------------------------------------------------------------------
  // In narrow mode an even block maps to bits 15-0 and an odd block to
  // bits 31-16 of the first word, which is the channel's low five bits.
  function automatic logic chan_sel(
    input logic [6:0] ch,
    input logic wide,
    input logic [1:0] even_sel,
    input logic [1:0] odd_sel,
    input logic [3:0][31:0] en
  );
    logic hit;
    hit = 1'b0;
    if (wide)
    begin
      hit = en[ch[6:5]][ch[4:0]];
    end
    else if (!ch[4] && (ch[6:5] == even_sel))
    begin
      hit = en[0][ch[4:0]];
    end
    else if (ch[4] && (ch[6:5] == odd_sel))
    begin
      hit = en[0][ch[4:0]];
    end
    return hit;
  endfunction

  // Next channel number from the frame and word strobes.
  function automatic logic [6:0] next_chan(
    input logic [6:0] ch,
    input logic frame_start,
    input logic word_done
  );
    logic [6:0] nc;
    nc = ch;
    if (frame_start)
    begin
      nc = 7'h00;
    end
    else if (word_done && (ch != mcs_pkg::LAST_CHAN))
    begin
      nc = 7'(ch + 7'h01);
    end
    return nc;
  endfunction

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  mcs_pkg::mcs_state_t s;
  mcs_pkg::mcs_state_t next_s;

  logic [3:0] page;
  logic [1:0] idx;
  logic word_ok;
  logic sel_tx;
  logic sel_rx_for_tx;
  logic sym;
  logic [1:0] tx_even;
  logic [1:0] tx_odd;

  assign page = bus.addr[7:4];
  assign idx = bus.addr[3:2];
  assign word_ok = (bus.addr[1:0] == 2'h0);

  // Register access, counters and channel decisions. Decisions are made
  // from the next state so every output except rdata agrees with the channel number
  // and control fields that are registered in the same edge.
  always_comb
  begin
    next_s = s;
    next_s.rdata = 32'h0000_0000;
    sel_tx = 1'b0;
    sel_rx_for_tx = 1'b0;
    sym = 1'b0;
    tx_even = 2'h0;
    tx_odd = 2'h0;
    // Writes; read-only and reserved control bits are dropped.
    if (bus.wr)
    begin
      if (bus.addr == mcs_pkg::OFF_CTRL)
      begin
        next_s.ctrl.rx_select_mode = bus.wdata[mcs_pkg::POS_RX_MODE];
        next_s.ctrl.rx_even_block_select =
          bus.wdata[mcs_pkg::POS_RX_EVEN +: 2];
        next_s.ctrl.rx_odd_block_select =
          bus.wdata[mcs_pkg::POS_RX_ODD +: 2];
        next_s.ctrl.rx_wide_select_enable =
          bus.wdata[mcs_pkg::POS_RX_WIDE];
        next_s.ctrl.tx_select_mode =
          mcs_pkg::mcs_tx_mode_t'(bus.wdata[mcs_pkg::POS_TX_MODE +: 2]);
        next_s.ctrl.tx_even_block_select =
          bus.wdata[mcs_pkg::POS_TX_EVEN +: 2];
        next_s.ctrl.tx_odd_block_select =
          bus.wdata[mcs_pkg::POS_TX_ODD +: 2];
        next_s.ctrl.tx_wide_select_enable =
          bus.wdata[mcs_pkg::POS_TX_WIDE];
      end
      else if (bus.addr == mcs_pkg::OFF_RX_BASIC)
      begin
        next_s.rx_en[0] = bus.wdata;
      end
      else if (bus.addr == mcs_pkg::OFF_TX_BASIC)
      begin
        next_s.tx_en[0] = bus.wdata;
      end
      else if (word_ok && (page == mcs_pkg::OFF_RX_EXT_PAGE))
      begin
        next_s.rx_en[idx] = bus.wdata;
      end
      else if (word_ok && (page == mcs_pkg::OFF_TX_EXT_PAGE))
      begin
        next_s.tx_en[idx] = bus.wdata;
      end
    end
    // Reads return the state before any write; unmapped reads give zero.
    if (bus.rd)
    begin
      if (bus.addr == mcs_pkg::OFF_CTRL)
      begin
        next_s.rdata[mcs_pkg::POS_RX_MODE] = s.ctrl.rx_select_mode;
        next_s.rdata[mcs_pkg::POS_RESERVED] = 1'b0;
        next_s.rdata[mcs_pkg::POS_RX_CUR +: 3] = s.rx_cur;
        next_s.rdata[mcs_pkg::POS_RX_EVEN +: 2] =
          s.ctrl.rx_even_block_select;
        next_s.rdata[mcs_pkg::POS_RX_ODD +: 2] =
          s.ctrl.rx_odd_block_select;
        next_s.rdata[mcs_pkg::POS_RX_WIDE] =
          s.ctrl.rx_wide_select_enable;
        next_s.rdata[mcs_pkg::POS_TX_MODE +: 2] = s.ctrl.tx_select_mode;
        next_s.rdata[mcs_pkg::POS_TX_CUR +: 3] = s.tx_cur;
        next_s.rdata[mcs_pkg::POS_TX_EVEN +: 2] =
          s.ctrl.tx_even_block_select;
        next_s.rdata[mcs_pkg::POS_TX_ODD +: 2] =
          s.ctrl.tx_odd_block_select;
        next_s.rdata[mcs_pkg::POS_TX_WIDE] =
          s.ctrl.tx_wide_select_enable;
      end
      else if (bus.addr == mcs_pkg::OFF_RX_BASIC)
      begin
        next_s.rdata = s.rx_en[0];
      end
      else if (bus.addr == mcs_pkg::OFF_TX_BASIC)
      begin
        next_s.rdata = s.tx_en[0];
      end
      else if (word_ok && (page == mcs_pkg::OFF_RX_EXT_PAGE))
      begin
        next_s.rdata = s.rx_en[idx];
      end
      else if (word_ok && (page == mcs_pkg::OFF_TX_EXT_PAGE))
      begin
        next_s.rdata = s.tx_en[idx];
      end
    end
    // Slot counters and current block.
    next_s.rx_chan = next_chan(s.rx_chan, slot.rx_frame_start,
      slot.rx_word_done);
    next_s.tx_chan = next_chan(s.tx_chan, slot.tx_frame_start,
      slot.tx_word_done);
    next_s.rx_cur = next_s.rx_chan[6:4];
    next_s.tx_cur = next_s.tx_chan[6:4];
    // Receive: enables are only looked at in selection mode.
    next_s.rx_accept = !next_s.ctrl.rx_select_mode ||
      chan_sel(next_s.rx_chan, next_s.ctrl.rx_wide_select_enable,
        next_s.ctrl.rx_even_block_select,
        next_s.ctrl.rx_odd_block_select, next_s.rx_en);
    // Symmetric mode takes its block choice from the receive side.
    sym = (next_s.ctrl.tx_select_mode == mcs_pkg::MCS_TX_SYMMETRIC);
    tx_even = sym ? next_s.ctrl.rx_even_block_select
                  : next_s.ctrl.tx_even_block_select;
    tx_odd = sym ? next_s.ctrl.rx_odd_block_select
                 : next_s.ctrl.tx_odd_block_select;
    sel_tx = chan_sel(next_s.tx_chan,
      next_s.ctrl.tx_wide_select_enable, tx_even, tx_odd, next_s.tx_en);
    sel_rx_for_tx = chan_sel(next_s.tx_chan,
      next_s.ctrl.tx_wide_select_enable, tx_even, tx_odd, next_s.rx_en);
    unique case (next_s.ctrl.tx_select_mode)
      mcs_pkg::MCS_TX_ALL:
      begin
        next_s.tx_enable = 1'b1;
        next_s.tx_unmask = 1'b1;
      end
      mcs_pkg::MCS_TX_SELECT:
      begin
        next_s.tx_enable = sel_tx;
        next_s.tx_unmask = sel_tx;
      end
      mcs_pkg::MCS_TX_MASKED:
      begin
        next_s.tx_enable = 1'b1;
        next_s.tx_unmask = sel_tx;
      end
      mcs_pkg::MCS_TX_SYMMETRIC:
      begin
        next_s.tx_enable = sel_rx_for_tx;
        next_s.tx_unmask = sel_tx;
      end
    endcase
    // The pin is driven only inside a packet on an enabled, unmasked slot.
    next_s.dx = slot.tx_bit;
    next_s.dx_oe = slot.tx_active && next_s.tx_enable &&
      next_s.tx_unmask;
  end

  // State register.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      s.ctrl <= mcs_pkg::RST_CTRL;
      s.rx_en <= {4{mcs_pkg::RST_ENABLE}};
      s.tx_en <= {4{mcs_pkg::RST_ENABLE}};
      s.rx_chan <= 7'h00;
      s.tx_chan <= 7'h00;
      s.rx_cur <= 3'h0;
      s.tx_cur <= 3'h0;
      s.rx_accept <= 1'b1;
      s.tx_enable <= 1'b1;
      s.tx_unmask <= 1'b1;
      s.dx <= 1'b0;
      s.dx_oe <= 1'b0;
      s.rdata <= 32'h0000_0000;
    end
    else
    begin
      s <= next_s;
    end
  end

  // Outputs come straight from the state register.
  assign rdata = s.rdata;
  assign rx_current_block = s.rx_cur;
  assign tx_current_block = s.tx_cur;
  assign rx_accept = s.rx_accept;
  assign tx_enable = s.tx_enable;
  assign tx_unmask = s.tx_unmask;
  assign serial_data_out_pin = s.dx;
  assign serial_data_out_pin_oe = s.dx_oe;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  a_block_tracks_chan: assert property (
    rx_current_block == s.rx_chan[6:4])
    else $error("Receive block does not follow channel count.");

  a_reserved_reads_zero: assert property (
    bus.rd && (bus.addr == mcs_pkg::OFF_CTRL) |=> !rdata[1])
    else $error("Reserved control bit read as one.");

  a_rx_open_all: assert property (
    !s.ctrl.rx_select_mode |-> rx_accept)
    else $error("Channel refused with selection off.");

  a_rx_unselected_off: assert property (
    s.ctrl.rx_select_mode && !s.ctrl.rx_wide_select_enable &&
    (s.rx_chan[6:5] != (s.rx_chan[4] ? s.ctrl.rx_odd_block_select
                                     : s.ctrl.rx_even_block_select))
    |-> !rx_accept)
    else $error("Channel outside selected blocks accepted.");

  a_rx_narrow_map: assert property (
    s.ctrl.rx_select_mode && !s.ctrl.rx_wide_select_enable &&
    (s.rx_chan[6:5] == (s.rx_chan[4] ? s.ctrl.rx_odd_block_select
                                     : s.ctrl.rx_even_block_select))
    |-> rx_accept == s.rx_en[0][s.rx_chan[4:0]])
    else $error("Narrow receive mapping wrong.");

  a_rx_wide_map: assert property (
    s.ctrl.rx_select_mode && s.ctrl.rx_wide_select_enable
    |-> rx_accept == s.rx_en[s.rx_chan[6:5]][s.rx_chan[4:0]])
    else $error("Wide receive mapping wrong.");

  a_tx_select_pair: assert property (
    s.ctrl.tx_select_mode == mcs_pkg::MCS_TX_SELECT
    |-> tx_enable == tx_unmask)
    else $error("Select mode enable and unmask differ.");

  a_tx_masked_on: assert property (
    s.ctrl.tx_select_mode == mcs_pkg::MCS_TX_MASKED |-> tx_enable)
    else $error("Masked mode disabled a channel.");

  a_tx_sym_mask: assert property (
    s.ctrl.tx_select_mode == mcs_pkg::MCS_TX_SYMMETRIC && !tx_unmask
    |-> !serial_data_out_pin_oe)
    else $error("Masked symmetric channel drove the pin.");

  a_pin_release: assert property (
    !slot.tx_active |=> !serial_data_out_pin_oe)
    else $error("Pin driven outside a packet.");

  a_frame_restart: assert property (
    slot.rx_frame_start |=> (s.rx_chan == 7'h00) && (rx_current_block == 3'h0))
    else $error("Frame sync did not restart the count.");

  // Transmit side. The pin must follow the decisions, so that a masked or
  // disabled slot never reaches the line even when the shifter is busy.
  a_tx_all_open: assert property (
    s.ctrl.tx_select_mode == mcs_pkg::MCS_TX_ALL |-> tx_enable && tx_unmask)
    else $error("Transmit slot blocked with selection off.");

  a_pin_gated: assert property (
    !(tx_enable && tx_unmask) |-> !serial_data_out_pin_oe)
    else $error("Masked or disabled slot drove the pin.");

  a_pin_follows_bit: assert property (
    serial_data_out_pin_oe |-> serial_data_out_pin == $past(slot.tx_bit))
    else $error("Driven pin does not carry the transmit bit.");

  a_tx_wide_map: assert property (
    s.ctrl.tx_select_mode == mcs_pkg::MCS_TX_MASKED &&
    s.ctrl.tx_wide_select_enable
    |-> tx_unmask == s.tx_en[s.tx_chan[6:5]][s.tx_chan[4:0]])
    else $error("Wide transmit mapping wrong.");

  a_tx_narrow_map: assert property (
    s.ctrl.tx_select_mode == mcs_pkg::MCS_TX_MASKED &&
    !s.ctrl.tx_wide_select_enable &&
    (s.tx_chan[6:5] == (s.tx_chan[4] ? s.ctrl.tx_odd_block_select
                                     : s.ctrl.tx_even_block_select))
    |-> tx_unmask == s.tx_en[0][s.tx_chan[4:0]])
    else $error("Narrow transmit mapping wrong.");

  a_tx_unselected_off: assert property (
    s.ctrl.tx_select_mode == mcs_pkg::MCS_TX_SELECT &&
    !s.ctrl.tx_wide_select_enable &&
    (s.tx_chan[6:5] != (s.tx_chan[4] ? s.ctrl.tx_odd_block_select
                                     : s.ctrl.tx_even_block_select))
    |-> !tx_enable)
    else $error("Transmit slot outside selected blocks enabled.");

  a_tx_sym_enable: assert property (
    s.ctrl.tx_select_mode == mcs_pkg::MCS_TX_SYMMETRIC &&
    s.ctrl.tx_wide_select_enable
    |-> tx_enable == s.rx_en[s.tx_chan[6:5]][s.tx_chan[4:0]])
    else $error("Symmetric enable does not follow receive bits.");

  c_rx_wide_accept: cover property (
    s.ctrl.rx_select_mode && s.ctrl.rx_wide_select_enable && rx_accept);
  c_tx_sym_drive: cover property (
    s.ctrl.tx_select_mode == mcs_pkg::MCS_TX_SYMMETRIC &&
    serial_data_out_pin_oe);
  c_last_block: cover property (rx_current_block == 3'h7);
  c_masked_hold: cover property (
    s.ctrl.tx_select_mode == mcs_pkg::MCS_TX_MASKED && !tx_unmask);

endmodule

`default_nettype wire

// >>> tb/mcs_framer_model.sv
/*
  Framer model on the far side of the channel-select block.
  Assumes the bench pulses start for one cycle to begin one frame.
*/
`timescale 1ns/10ps
`default_nettype none

module mcs_framer_model
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Bench control
  input wire logic start,
  output logic busy,
  // Strobes and transmit bit towards the block
  output var mcs_pkg::mcs_slot_t slot
);
  int cnt;
  int seed = 32'h59e147ec;

  // Frame start, then 128 word strobes; the last one lies in the gap.
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cnt <= 0;
      slot <= '0;
    end
    else
    begin
      cnt <= start ? 1 : (cnt == 0 || cnt == 129) ? 0 : cnt + 1;
      slot.rx_frame_start <= start;
      slot.tx_frame_start <= start;
      slot.rx_word_done <= cnt >= 1 && cnt <= 128;
      slot.tx_word_done <= cnt >= 1 && cnt <= 128;
      slot.tx_active <= start || (cnt >= 1 && cnt < 128);
      // A released line toggles so that no stale bit looks valid.
      slot.tx_bit <= busy ? 1'($random(seed)) : ~slot.tx_bit;
    end
  end

  assign busy = cnt != 0;

endmodule
`default_nettype wire

// >>> tb/mcs_channel_select_bench.sv
/*
  Self-checking bench of the channel-select block.
  Assumes the framer model drives the slot strobes and transmit bits.
*/
`timescale 1ns/10ps
`default_nettype none

module mcs_channel_select_bench;
  logic clk;
  logic rstn;
  logic start;
  logic busy;
  mcs_pkg::mcs_bus_t bus;
  mcs_pkg::mcs_slot_t slot;
  logic [31:0] rdata;
  logic [2:0] rxb;
  logic [2:0] txb;
  logic acc;
  logic en;
  logic un;
  logic pin;
  logic oe;
  int miscompares = 0;
  int compares = 0;
  int seed = 32'h59e147ec;
  logic [9:0] exp_q[$];
  logic [31:0] rd_q[$];
  logic pend = 1'b0;
  logic rd_pend = 1'b0;
  logic bit_d = 1'b0;
  logic [3:0][31:0] rx;
  logic [3:0][31:0] tx;
  logic [31:0] w;
  logic [2:0] cur;
  logic [7:0] addrs[12] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h14, 8'h18,
    8'h1C, 8'h20, 8'h24, 8'h28, 8'h2C, 8'h30};

  mcs_channel_select mcs_channel_select_inst (.clk(clk), .rstn(rstn),
    .bus(bus), .rdata(rdata), .slot(slot), .rx_current_block(rxb),
    .tx_current_block(txb), .rx_accept(acc), .tx_enable(en),
    .tx_unmask(un), .serial_data_out_pin(pin),
    .serial_data_out_pin_oe(oe));

  mcs_framer_model mcs_framer_model_inst (.clk(clk), .rstn(rstn),
    .start(start), .busy(busy), .slot(slot));

  // ------------------------------------------------------------
  // Clock, watchdog and closing
  // ------------------------------------------------------------
  // Free-running 25 MHz clock.
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // The run needs under 2000 cycles; ten times that means a hang.
  initial
  begin
    repeat (20000) @(posedge clk);
    miscompares++;
    end_of_test();
  end

  task automatic end_of_test();
    miscompares += exp_q.size() + rd_q.size();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ------------------------------------------------------------
  // Compare tasks and reference
  // ------------------------------------------------------------
  task automatic check_slot(input logic [9:0] e);
    compares++;
    if ({rxb, txb, acc, en, un, oe} !== e)
    begin
      miscompares++;
      $display("unexpected decisions: expected %h seen %h", e,
        {rxb, txb, acc, en, un, oe});
    end
  endtask

  task automatic check_read(input logic [31:0] e);
    compares++;
    if (rdata !== e)
    begin
      miscompares++;
      $display("unexpected rdata: expected %h seen %h", e, rdata);
    end
  endtask

  task automatic check_pin(input logic e);
    compares++;
    if (pin !== e)
    begin
      miscompares++;
      $display("unexpected data pin: expected %b seen %b", e, pin);
    end
  endtask

  // Enable bit of one channel under narrow or wide mapping.
  function automatic logic en_bit(input logic [6:0] c, input logic wd,
    input logic [1:0] ev, input logic [1:0] od, input logic [3:0][31:0] r);
    if (wd)
      return r[c[6:5]][c[4:0]];
    if (c[6:4] == {ev, 1'b0})
      return r[0][{1'b0, c[3:0]}];
    if (c[6:4] == {od, 1'b1})
      return r[0][{1'b1, c[3:0]}];
    return 1'b0;
  endfunction

  // Expected decisions for channel c under the control word w.
  function automatic logic [9:0] slot_exp(input logic [6:0] c,
    input logic a);
    logic r;
    logic s;
    logic e;
    logic u;
    r = !w[0] | en_bit(c, w[9], w[6:5], w[8:7], rx);
    s = en_bit(c, w[25], w[22:21], w[24:23], tx);
    case (w[17:16])
      mcs_pkg::MCS_TX_ALL: {e, u} = 2'b11;
      mcs_pkg::MCS_TX_SELECT: {e, u} = {s, s};
      mcs_pkg::MCS_TX_MASKED: {e, u} = {1'b1, s};
      default: {e, u} = {en_bit(c, w[25], w[6:5], w[8:7], rx),
        en_bit(c, w[25], w[6:5], w[8:7], tx)};
    endcase
    return {c[6:4], c[6:4], r, e, u, a & e & u};
  endfunction

  // ------------------------------------------------------------
  // Drivers
  // ------------------------------------------------------------
  // Each access waits for an edge first, so back to back is safe.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    rd_q.push_back(e);
  endtask

  task automatic run_frame();
    @(posedge clk);
    bus <= '0;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    repeat (200)
    begin
      @(negedge clk);
      if (!busy)
        break;
    end
  endtask

  // Results appear the cycle after a strobe or read; seen at negedge.
  always @(negedge clk)
  begin
    if (rd_pend)
      check_read(rd_q.pop_front());
    if (pend)
    begin
      check_slot(exp_q.pop_front());
      if (oe === 1'b1)
        check_pin(bit_d);
    end
    rd_pend = bus.rd;
    pend = slot.rx_frame_start | slot.rx_word_done;
    bit_d = slot.tx_bit;
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    rstn = 1'b0;
    bus = '0;
    start = 1'b0;
    cur = 3'h0;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    @(negedge clk);
    check_slot(10'h00E);
    foreach (addrs[i])
      rd(addrs[i], 32'h0);
    wr(8'h30, 32'hFFFFFFFF);
    rd(8'h30, 32'h0);
    // Each frame covers one transmit mode and one mix of wide bits.
    for (int i = 0; i < 8; i++)
    begin
      w = $random(seed);
      w[0] = i[2];
      w[9] = i[0];
      w[17:16] = i[1:0];
      w[25] = i[1] ^ i[2];
      wr(8'h00, w);
      rd(8'h00, (w & 32'h03E303E1) | {11'h0, cur, 13'h0, cur, 2'h0});
      for (int k = 0; k < 4; k++)
      begin
        rx[k] = $random(seed);
        tx[k] = $random(seed);
        wr(8'h10 + 8'(4 * k), rx[k]);
        wr(8'h20 + 8'(4 * k), tx[k]);
      end
      rd(8'h04, rx[0]);
      rd(8'h08, tx[0]);
      rd(8'h1C, rx[3]);
      rd(8'h2C, tx[3]);
      for (int c = 0; c < 128; c++)
        exp_q.push_back(slot_exp(7'(c), 1'b1));
      // The extra word strobe is refused and falls in the gap.
      exp_q.push_back(slot_exp(7'h7F, 1'b0));
      run_frame();
      cur = 3'h7;
    end
    @(negedge clk);
    end_of_test();
  end

endmodule
`default_nettype wire
